// file: design/sclk_ctrl.sv
// sample clock control: rate rounding, oversampling, reference mode, pll start and lock
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
module sclk_ctrl import sclk_pkg::*; #(
  parameter logic [31:0] P_MAX_RATE_HZ = MAX_RATE_DEF_HZ,
  parameter logic [31:0] P_MIN_NATIVE_HZ = MIN_NATIVE_DEF_HZ,
  parameter int P_MS_CYC = MS_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [17:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_irq,
  input wire logic i_ext_clk_present,
  input wire logic i_pll_locked,
  output logic o_pll_program,
  output logic o_pll_ref_ext,
  output logic [31:0] o_pll_ref_hz,
  output logic [4:0] o_conv_exp,
  output logic [4:0] o_digital_exp,
  output logic o_clkout_oe,
  output logic o_card_running
);
  // ----------------------------------------------------------------
  // rate arithmetic
  // ----------------------------------------------------------------
  function automatic logic [4:0] exp_of(input logic [31:0] hz);
    logic [4:0] e;
    e = 5'h00;
    for (int i = 0; i <= DIV_EXP_MAX; i++) begin
      if ((P_MAX_RATE_HZ >> i) >= hz) begin
        e = 5'(i);
      end
    end
    return e;
  endfunction

  localparam logic [4:0] NAT_EXP = exp_of(P_MIN_NATIVE_HZ);

  logic [31:0] rate_q, ref_q, os_factor_w, rounded_w, clk_freq_w;
  logic ext_mode_q, clkout_q;
  logic [4:0] rate_exp_w, conv_exp_w, os_exp_w;

  assign rate_exp_w = exp_of(rate_q);
  assign rounded_w = P_MAX_RATE_HZ >> rate_exp_w;
  // converter never goes below its native floor; the rest is oversampling
  assign conv_exp_w = (rate_exp_w > NAT_EXP) ? NAT_EXP : rate_exp_w;
  assign os_exp_w = rate_exp_w - conv_exp_w;
  assign os_factor_w = 32'h00000001 << os_exp_w;
  assign clk_freq_w = P_MAX_RATE_HZ >> conv_exp_w;

  // ----------------------------------------------------------------
  // pins and divider
  // ----------------------------------------------------------------
  logic ext_s, lock_s, tick_w, prog_q, run_q;
  sclk_state_type state_q, state_d;

  sclk_sync3 u_sync_ext (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_pin(i_ext_clk_present),
    .o_level(ext_s)
  );

  sclk_sync3 u_sync_lock (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_pin(i_pll_locked),
    .o_level(lock_s)
  );

  sclk_tick #(
    .P_DIV(P_MS_CYC)
  ) u_ms_tick (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_clear(state_q == ST_PROG),
    .o_tick(tick_w)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic wr_rate_w, wr_clkout_w, wr_ref_w, wr_src_w, wr_cmd_w, wr_mask_w;
  logic rd_irq_w, start_w, stop_w, src_legal_w;

  assign wr_rate_w = i_wr && (i_addr == ADDR_SAMPLE_RATE);
  assign wr_clkout_w = i_wr && (i_addr == ADDR_CLKOUT_EN);
  assign wr_ref_w = i_wr && (i_addr == ADDR_REF_HZ);
  assign wr_src_w = i_wr && (i_addr == ADDR_CLK_SRC);
  assign wr_cmd_w = i_wr && (i_addr == ADDR_CARD_CMD);
  assign wr_mask_w = i_wr && (i_addr == ADDR_IRQ_MASK);
  assign rd_irq_w = i_rd && (i_addr == ADDR_IRQ_STAT);
  assign start_w = wr_cmd_w && i_wdata[CMD_START_BIT];
  assign stop_w = wr_cmd_w && i_wdata[CMD_STOP_BIT];
  assign src_legal_w = (i_wdata == MODE_INT_PLL) || (i_wdata == MODE_EXT_REF);

  // unknown mode codes are dropped so the source select always holds a legal mode
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rate_q <= RATE_RST;
      ref_q <= REF_RST;
      ext_mode_q <= 1'b0;
      clkout_q <= 1'b0;
    end else begin
      if (wr_rate_w) rate_q <= i_wdata;
      if (wr_ref_w) ref_q <= i_wdata;
      if (wr_src_w && src_legal_w) ext_mode_q <= (i_wdata == MODE_EXT_REF);
      if (wr_clkout_w) clkout_q <= i_wdata[0];
    end
  end

  // ----------------------------------------------------------------
  // start sequence
  // ----------------------------------------------------------------
  logic app_vld_q, app_ext_q, changed_w, no_ext_w, lock_ok_w, timeout_w;
  logic [31:0] app_ref_q;
  logic [4:0] app_exp_q, app_conv_q, app_os_q;
  logic [7:0] ms_q, result_q, result_d;
  logic [IRQ_W-1:0] ev_w;

  assign changed_w = !app_vld_q || (app_ext_q != ext_mode_q) ||
                     (app_ref_q != ref_q) || (app_exp_q != rate_exp_w);
  assign no_ext_w = ext_mode_q && !ext_s;
  // a stale lock from the old setting may linger, so it is ignored for the first LOCK_MIN_MS (10) ms
  assign lock_ok_w = lock_s && (ms_q >= LOCK_MIN_MS);
  assign timeout_w = ms_q >= LOCK_MAX_MS;

  always_comb begin
    state_d = state_q;
    result_d = result_q;
    ev_w = '0;
    case (state_q)
      ST_IDLE: begin
        if (start_w && no_ext_w) begin
          result_d = RES_NO_EXT_CLK;
          ev_w[IRQ_START_FAIL] = 1'b1;
        end else if (start_w && (changed_w || !lock_s)) begin
          state_d = ST_PROG;
        end else if (start_w) begin
          state_d = ST_RUN;
          result_d = RES_OK;
          ev_w[IRQ_START_DONE] = 1'b1;
        end
      end
      ST_PROG: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (lock_ok_w) begin
          state_d = ST_RUN;
          result_d = RES_OK;
          ev_w[IRQ_START_DONE] = 1'b1;
        end else if (timeout_w) begin
          state_d = ST_IDLE;
          result_d = RES_NOT_LOCKED;
          ev_w[IRQ_START_FAIL] = 1'b1;
        end
      end
      ST_RUN: begin
        if (stop_w) begin
          state_d = ST_IDLE;
        end else if (!lock_s) begin
          state_d = ST_IDLE;
          result_d = RES_NOT_LOCKED;
          ev_w[IRQ_LOCK_LOST] = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      result_q <= RES_OK;
      ms_q <= 8'h00;
      prog_q <= 1'b0;
      run_q <= 1'b0;
    end else begin
      state_q <= state_d;
      result_q <= result_d;
      prog_q <= (state_d == ST_PROG);
      run_q <= (state_d == ST_RUN);
      if (state_q == ST_PROG) ms_q <= 8'h00;
      else if (state_q == ST_WAIT && tick_w) ms_q <= ms_q + 8'h01;
    end
  end

  // the pll always sits in the path, also for a one-to-one copy of the reference
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      app_vld_q <= 1'b0;
      app_ext_q <= 1'b0;
      app_ref_q <= REF_RST;
      app_exp_q <= 5'h00;
      app_conv_q <= 5'h00;
      app_os_q <= 5'h00;
    end else if (state_q == ST_IDLE && state_d == ST_PROG) begin
      app_vld_q <= 1'b1;
      app_ext_q <= ext_mode_q;
      app_ref_q <= ref_q;
      app_exp_q <= rate_exp_w;
      app_conv_q <= conv_exp_w;
      app_os_q <= os_exp_w;
    end else if (state_q == ST_WAIT && state_d == ST_IDLE) begin
      app_vld_q <= 1'b0; // a failed lock forces a fresh attempt next start
    end
  end

  // ----------------------------------------------------------------
  // interrupts and read port
  // ----------------------------------------------------------------
  logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_stat_d;
  logic [31:0] status_w, rd_val_w, rdata_q;
  logic irq_q;

  // a new event in the clearing read cycle survives
  assign irq_stat_d = (rd_irq_w ? '0 : irq_stat_q) | ev_w;
  assign status_w = {28'h0000000, ext_s, state_q != ST_IDLE && state_q != ST_RUN,
                     state_q == ST_RUN, lock_s};
  assign rd_val_w =
    (i_addr == ADDR_SAMPLE_RATE) ? rounded_w :
    (i_addr == ADDR_CLKOUT_EN) ? {31'h00000000, clkout_q} :
    (i_addr == ADDR_CLKOUT_FREQ) ? clk_freq_w :
    (i_addr == ADDR_REF_HZ) ? ref_q :
    (i_addr == ADDR_CLK_SRC) ? (ext_mode_q ? MODE_EXT_REF : MODE_INT_PLL) :
    (i_addr == ADDR_OVERSAMPLE) ? os_factor_w :
    (i_addr == ADDR_CARD_RESULT) ? {24'h000000, result_q} :
    (i_addr == ADDR_STATUS) ? status_w :
    (i_addr == ADDR_IRQ_STAT) ? {29'h00000000, irq_stat_q} :
    (i_addr == ADDR_IRQ_MASK) ? {29'h00000000, irq_mask_q} : 32'h00000000;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      rdata_q <= 32'h00000000;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_mask_w) irq_mask_q <= i_wdata[IRQ_W-1:0];
      rdata_q <= i_rd ? rd_val_w : 32'h00000000;
      irq_q <= |(irq_stat_d & irq_mask_q);
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = irq_q;
  assign o_pll_program = prog_q;
  assign o_pll_ref_ext = app_ext_q;
  assign o_pll_ref_hz = app_ref_q;
  assign o_conv_exp = app_conv_q;
  assign o_digital_exp = app_os_q;
  assign o_clkout_oe = clkout_q;
  assign o_card_running = run_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  a_os_one_native:
    assert property ((rate_exp_w <= NAT_EXP) |-> (os_factor_w == 32'h00000001))
    else $error("oversample factor not one at native rate");
  a_conv_floor:
    assert property ((conv_exp_w <= NAT_EXP) && (os_exp_w + conv_exp_w == rate_exp_w))
    else $error("converter clock below native floor");
  a_clkout_freq:
    assert property (((clk_freq_w >> os_exp_w) == rounded_w) && (clk_freq_w >= P_MIN_NATIVE_HZ))
    else $error("clock output frequency not rate times factor");
  a_ext_routed:
    assert property ((state_q == ST_IDLE) && start_w && ext_mode_q && ext_s && changed_w
                     |=> ##1 o_pll_ref_ext && o_pll_program == 1'b0)
    else $error("external reference not routed to pll");
  a_refuse_noclk:
    assert property ((state_q == ST_IDLE) && start_w && no_ext_w
                     |=> (state_q == ST_IDLE) && (result_q == RES_NO_EXT_CLK))
    else $error("start accepted without external clock");
  a_prog_changed:
    assert property ((state_q == ST_IDLE) && start_w && !no_ext_w && changed_w
                     |=> o_pll_program ##1 (state_q == ST_WAIT))
    else $error("changed settings not reprogrammed");
  a_no_reprog:
    assert property ((state_q == ST_IDLE) && start_w && !no_ext_w && !changed_w && lock_s
                     |=> o_card_running && !o_pll_program)
    else $error("pll reprogrammed without change");
  a_lock_early:
    assert property ((state_q == ST_WAIT) && (ms_q < LOCK_MIN_MS) |=> !o_card_running)
    else $error("lock accepted before minimum wait");
  a_lock_fail:
    assert property ((state_q == ST_WAIT) && timeout_w && !lock_s
                     |=> (state_q == ST_IDLE) && (result_q == RES_NOT_LOCKED))
    else $error("lock timeout not reported");
  a_clkout_oe:
    assert property (wr_clkout_w |=> (o_clkout_oe == $past(i_wdata[0])))
    else $error("clock output enable not following write");
  a_freq_read:
    assert property (i_rd && (i_addr == ADDR_CLKOUT_FREQ) |=> (o_rdata == $past(clk_freq_w)))
    else $error("clock output frequency read wrong");
  a_rate_round:
    assert property ((rate_q <= P_MAX_RATE_HZ) && (rate_q != 32'h00000000)
                     |-> (rounded_w >= rate_q) &&
                         ((rate_exp_w == 5'(DIV_EXP_MAX)) || ((rounded_w >> 1) < rate_q)))
    else $error("rate not rounded to next divided rate");
  a_lock_status:
    assert property (i_rd && (i_addr == ADDR_STATUS) |=> (o_rdata[STAT_LOCK] == $past(lock_s)))
    else $error("lock status bit wrong");

  c_start_locked: cover property ((state_q == ST_WAIT) ##1 (state_q == ST_RUN));
  c_start_timeout: cover property ((state_q == ST_WAIT) ##1 (result_q == RES_NOT_LOCKED));
  c_start_noclk: cover property (start_w && no_ext_w);
  c_lock_lost: cover property (ev_w[IRQ_LOCK_LOST]);
endmodule // sclk_ctrl

// file: design/sclk_pkg.sv
// package: register map, encodings and timing constants of the sample clock control
package sclk_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYC = CLK_HZ / MS_PER_S;
  localparam logic [7:0] LOCK_MIN_MS = 8'h0A;
  localparam logic [7:0] LOCK_MAX_MS = 8'hC8;
  // ----------------------------------------------------------------
  // rate limits, plain defaults
  // ----------------------------------------------------------------
  localparam logic [31:0] MAX_RATE_DEF_HZ = 32'h3B9ACA00;
  localparam logic [31:0] MIN_NATIVE_DEF_HZ = 32'h05F5E100;
  localparam int DIV_EXP_MAX = 17;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [17:0] ADDR_SAMPLE_RATE = 18'h04E20;
  localparam logic [17:0] ADDR_CLKOUT_EN = 18'h04E8E;
  localparam logic [17:0] ADDR_CLKOUT_FREQ = 18'h04E8F;
  localparam logic [17:0] ADDR_REF_HZ = 18'h04EAC;
  localparam logic [17:0] ADDR_CLK_SRC = 18'h04EE8;
  localparam logic [17:0] ADDR_OVERSAMPLE = 18'h30DBB;
  localparam logic [17:0] ADDR_CARD_CMD = 18'h00100;
  localparam logic [17:0] ADDR_CARD_RESULT = 18'h00104;
  localparam logic [17:0] ADDR_STATUS = 18'h00108;
  localparam logic [17:0] ADDR_IRQ_STAT = 18'h0010C;
  localparam logic [17:0] ADDR_IRQ_MASK = 18'h00110;
  // ----------------------------------------------------------------
  // field values and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] MODE_INT_PLL = 32'h00000001;
  localparam logic [31:0] MODE_EXT_REF = 32'h00000020;
  localparam int CMD_START_BIT = 0;
  localparam int CMD_STOP_BIT = 1;
  localparam logic [7:0] RES_OK = 8'h00;
  localparam logic [7:0] RES_NOT_LOCKED = 8'h01;
  localparam logic [7:0] RES_NO_EXT_CLK = 8'h02;
  localparam logic [31:0] RATE_RST = 32'h3B9ACA00;
  localparam logic [31:0] REF_RST = 32'h00989680;
  localparam int IRQ_W = 3;
  localparam int IRQ_START_DONE = 0;
  localparam int IRQ_START_FAIL = 1;
  localparam int IRQ_LOCK_LOST = 2;
  localparam int STAT_LOCK = 0;
  localparam int STAT_RUN = 1;
  localparam int STAT_BUSY = 2;
  localparam int STAT_EXT_CLK = 3;
  // ----------------------------------------------------------------
  // start sequence states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PROG = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_RUN = 4'b1000
  } sclk_state_type;
endpackage

// file: design/sclk_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module sclk_sync3 (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_pin,
  output logic o_level
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;

  // only the second stage reads the first
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end

  assign o_level = lvl_q;
endmodule // sclk_sync3

// file: design/sclk_tick.sv
// clearable divider giving a one-cycle enable pulse every P_DIV cycles
`timescale 1ns/1ns
module sclk_tick #(
  parameter int P_DIV = 50000
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clear,
  output logic o_tick
);
  logic [31:0] cnt_q;
  logic tick_q;
  logic wrap_w;

  assign wrap_w = (cnt_q == 32'(P_DIV - 1));

  always_ff @(posedge i_ref_clk) begin
    if (i_reset || i_clear) begin
      cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= wrap_w ? 32'h00000000 : cnt_q + 32'h00000001;
      tick_q <= wrap_w;
    end
  end

  assign o_tick = tick_q;
endmodule // sclk_tick

// file: dv/sclk_ref_model.sv
// partner model: external reference source and pll lock as seen by the control block
`timescale 1ns/1ns
// ----------------------------------------------------------------
// partner model
// ----------------------------------------------------------------
module sclk_ref_model #(
  parameter int P_LOCK_CYC = 150
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_clk_on,
  input wire logic i_lock_ok,
  input wire logic i_pll_program,
  input wire logic i_pll_ref_ext,
  output logic o_ext_clk_present,
  output logic o_pll_locked
);
  int cnt_q;
  logic src_ok;
  // a gap in the source shows at once as absent, never as a held level
  assign o_ext_clk_present = i_clk_on;
  assign src_ok = i_clk_on || !i_pll_ref_ext;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || i_pll_program) begin
      cnt_q <= 0;
    end else if (cnt_q < P_LOCK_CYC) begin
      cnt_q <= cnt_q + 1;
    end
  end
  // reprogramming drops lock; an absent or bad source never locks
  assign o_pll_locked = i_lock_ok && src_ok && (cnt_q >= P_LOCK_CYC);
endmodule // sclk_ref_model

// file: dv/testbench.sv
// self-checking testbench of the sample clock control block
`timescale 1ns/1ns
module testbench import sclk_pkg::*; ;
  logic i_ref_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [17:0] i_addr = 18'h00000;
  logic [31:0] i_wdata = 32'h00000000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic clk_on = 1'b0;
  logic lock_ok = 1'b1;
  logic rd_d = 1'b0;
  logic [31:0] o_rdata, o_pll_ref_hz, rnd, ref_hz;
  logic o_irq, ext_present, pll_locked, o_pll_program, o_pll_ref_ext, o_clkout_oe;
  logic o_card_running;
  logic [4:0] o_conv_exp, o_digital_exp;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int total_checks = 0;
  int n;
  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  sclk_ctrl #(.P_MS_CYC(10)) uut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .i_ext_clk_present(ext_present), .i_pll_locked(pll_locked),
    .o_pll_program(o_pll_program), .o_pll_ref_ext(o_pll_ref_ext), .o_pll_ref_hz(o_pll_ref_hz),
    .o_conv_exp(o_conv_exp), .o_digital_exp(o_digital_exp), .o_clkout_oe(o_clkout_oe),
    .o_card_running(o_card_running));
  sclk_ref_model model (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_clk_on(clk_on),
    .i_lock_ok(lock_ok), .i_pll_program(o_pll_program), .i_pll_ref_ext(o_pll_ref_ext),
    .o_ext_clk_present(ext_present), .o_pll_locked(pll_locked));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge i_ref_clk);
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
  endtask
  // bounded wait on the interrupt (sel 1) or on the running flag (sel 0)
  task automatic wait_for(input logic sel);
    n = 0;
    while ((sel ? o_irq : o_card_running) !== 1'b1 && n < 3000) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
  endtask
  task automatic start_prog();
    wr(ADDR_CARD_CMD, 32'h00000001);
    #1;
    check({31'h0, o_pll_program}, 32'h1);
    check({31'h0, o_pll_ref_ext}, 32'h1);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) rd_d <= i_rd;
  // read data stand only in the cycle after the strobe, so look there
  always @(negedge i_ref_clk) begin
    if (rd_d && exp_q.size() > 0) check(o_rdata, exp_q.pop_front());
  end
  initial begin
    cyc(20000);
    miscompares++;
    test_done;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rnd = 32'h0000002B;
    cyc(5);
    i_reset <= 1'b0;
    rd(ADDR_REF_HZ, REF_RST);
    rd(ADDR_CLK_SRC, MODE_INT_PLL);
    rd(ADDR_OVERSAMPLE, 32'h00000001);
    rd(ADDR_CLKOUT_FREQ, 32'h3B9ACA00);
    rd(18'h00200, 32'h00000000);
    wr(ADDR_CLKOUT_EN, 32'h00000001);
    #1;
    check({31'h0, o_clkout_oe}, 32'h1);
    rd(ADDR_CLKOUT_EN, 32'h00000001);
    wr(ADDR_CLKOUT_EN, 32'h00000000);
    #1;
    check({31'h0, o_clkout_oe}, 32'h0);
    wr(ADDR_SAMPLE_RATE, 32'h13DE4355);
    rd(ADDR_SAMPLE_RATE, 32'h1DCD6500);
    wr(ADDR_SAMPLE_RATE, 32'h00000001);
    rd(ADDR_SAMPLE_RATE, 32'h00001DCD);
    rd(ADDR_OVERSAMPLE, 32'h00004000);
    wr(ADDR_SAMPLE_RATE, 32'h01DCD650);
    wr(ADDR_OVERSAMPLE, 32'h00000005);
    rd(ADDR_OVERSAMPLE, 32'h00000004);
    rd(ADDR_CLKOUT_FREQ, 32'h07735940);
    wr(ADDR_CLK_SRC, 32'h00000007);
    rd(ADDR_CLK_SRC, MODE_INT_PLL);
    // external mode without a source: start is refused
    wr(ADDR_IRQ_MASK, 32'h00000007);
    wr(ADDR_CLK_SRC, MODE_EXT_REF);
    wr(ADDR_CARD_CMD, 32'h00000001);
    cyc(2);
    #1;
    check({31'h0, o_irq}, 32'h1);
    rd(ADDR_CARD_RESULT, {24'h0, RES_NO_EXT_CLK});
    rd(ADDR_IRQ_STAT, 32'h00000002);
    // source present from here on, switched on at a clock edge
    clk_on <= 1'b1;
    cyc(2);
    #1;
    check({31'h0, o_irq}, 32'h0);
    // declared frequency random: lock after the wait
    rnd = lfsr(rnd);
    ref_hz = rnd;
    cyc(8);
    wr(ADDR_REF_HZ, ref_hz);
    rd(ADDR_REF_HZ, ref_hz);
    start_prog();
    check(o_pll_ref_hz, ref_hz);
    check({27'h0, o_conv_exp}, 32'h3);
    check({27'h0, o_digital_exp}, 32'h2);
    wait_for(1'b0);
    check(32'(n >= 100 && n < 2000), 32'h1);
    rd(ADDR_CARD_RESULT, {24'h0, RES_OK});
    rd(ADDR_IRQ_STAT, 32'h00000001);
    rd(ADDR_STATUS, 32'h0000000B);
    // unchanged settings with lock held: no relock
    wr(ADDR_CARD_CMD, 32'h00000002);
    cyc(2);
    wr(ADDR_CARD_CMD, 32'h00000001);
    #1;
    check({31'h0, o_card_running}, 32'h1);
    check({31'h0, o_pll_program}, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h00000001);
    // lock lost while running
    lock_ok <= 1'b0;
    cyc(8);
    #1;
    check({31'h0, o_card_running}, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h00000004);
    rd(ADDR_CARD_RESULT, {24'h0, RES_NOT_LOCKED});
    rd(ADDR_STATUS, 32'h00000008);
    // no lock at all: start fails after the longest wait
    start_prog();
    wait_for(1'b1);
    check(32'(n >= 1990 && n <= 2100), 32'h1);
    rd(ADDR_CARD_RESULT, {24'h0, RES_NOT_LOCKED});
    rd(ADDR_IRQ_STAT, 32'h00000002);
    // rate equal to the reference, done interrupt masked
    wr(ADDR_IRQ_MASK, 32'h00000000);
    lock_ok <= 1'b1;
    wr(ADDR_REF_HZ, 32'h01DCD650);
    start_prog();
    wait_for(1'b0);
    check({31'h0, o_card_running}, 32'h1);
    check({31'h0, o_irq}, 32'h0);
    rd(ADDR_IRQ_STAT, 32'h00000001);
    cyc(3);
    test_done;
  end
endmodule // testbench
